// ===== qps_pkg.sv
// constants, field layout and types of the qos policer/shaper/scheduler
// assumes one 125 mhz clock shared by every module of the block
`default_nettype none
package qps_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TICK_NS = 1000;
	localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int unsigned NQ = 8;
	localparam int unsigned QW = 3;
	localparam int unsigned RATE_W = 20;
	localparam int unsigned WGT_W = 7;
	localparam int unsigned LEN_W = 16;
	localparam int unsigned LVL_W = 40;
	localparam int unsigned ADDR_W = 12;

	// ----------------------------------------------------------------
	// value limits and reset values
	// ----------------------------------------------------------------
	localparam logic [RATE_W-1:0] RATE_DEF = 20'h001f4;
	localparam logic [RATE_W-1:0] RATE_FINE_MIN = 20'h00064;
	localparam logic [RATE_W-1:0] RATE_FINE_MAX = 20'hf4240;
	localparam logic [RATE_W-1:0] RATE_COARSE_MIN = 20'h00001;
	localparam logic [RATE_W-1:0] RATE_COARSE_MAX = 20'h00ce4;
	localparam logic [WGT_W-1:0] WGT_DEF = 7'h11;
	localparam logic [WGT_W-1:0] WGT_MIN = 7'h01;
	localparam logic [WGT_W-1:0] WGT_MAX = 7'h64;
	localparam logic [13:0] PCT_FULL = 14'h0064;

	// ----------------------------------------------------------------
	// token bucket scaling: tokens are millibits or microframes
	// ----------------------------------------------------------------
	localparam logic [LVL_W-1:0] SCALE_COARSE = 40'h00000003e8;
	localparam logic [LVL_W-1:0] COST_BYTE = 40'h0000001f40;
	localparam logic [LVL_W-1:0] COST_FRAME = 40'h00000f4240;
	localparam logic [LVL_W-1:0] BUCKET_CAP = 40'h0010000000;

	// ----------------------------------------------------------------
	// meter slots
	// ----------------------------------------------------------------
	localparam int unsigned MET_PPOL = 0;
	localparam int unsigned MET_QPOL = 1;
	localparam int unsigned MET_QSHP = 9;
	localparam int unsigned MET_PSHP = 17;
	localparam int unsigned MET_N = 18;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_PPOL_CFG = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_PPOL_RATE = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_QPOL_CFG = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_QPOL_RATE = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_SCHED_CFG = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_QSHP_CFG = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_PSHP_CFG = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_PSHP_RATE = 12'h01c;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_DROP_CNT = 12'h024;
	localparam logic [ADDR_W-1:0] OFS_QSHP_RATE = 12'h040;
	localparam logic [ADDR_W-1:0] OFS_WGT = 12'h060;
	localparam logic [ADDR_W-1:0] OFS_PCT = 12'h080;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned PPOL_EN_BIT = 0;
	localparam int unsigned PPOL_UNIT_LSB = 1;
	localparam int unsigned PPOL_FC_BIT = 3;
	localparam int unsigned QPOL_UNIT_BIT = 8;
	localparam int unsigned QSHP_EXC_LSB = 8;
	localparam int unsigned QSHP_UNIT_BIT = 16;
	localparam int unsigned PSHP_EN_BIT = 0;
	localparam int unsigned PSHP_UNIT_BIT = 1;
	localparam int unsigned SCHED_WTD_BIT = 0;
	localparam int unsigned STAT_GNT_LSB = 8;
	localparam int unsigned STAT_PSHP_BIT = 16;
	localparam int unsigned STAT_PPOL_BIT = 17;

	// bit0 picks the coarse scale, bit1 picks frame counting
	typedef enum logic [1:0] {
		QPS_KBPS = 2'h0,
		QPS_MBPS = 2'h1,
		QPS_FPS = 2'h2,
		QPS_KFPS = 2'h3
	} qps_unit_t;
endpackage
`default_nettype wire

// ===== qps_meter_if.sv
// bundle between the control logic and one token bucket meter
// assumes the owner drives config and events on the common clock
`default_nettype none
interface qps_meter_if;
	logic en;
	qps_pkg::qps_unit_t unit;
	logic [qps_pkg::RATE_W-1:0] rate;
	logic tick;
	logic debit;
	logic [qps_pkg::LEN_W-1:0] len;
	logic conform;
	modport ctl (output en, unit, rate, tick, debit, len, input conform);
	modport meter (input en, unit, rate, tick, debit, len, output conform);
endinterface
`default_nettype wire

// ===== qps_meter.sv
// token bucket meter used for policers and shapers alike
// assumes tick pulses once per microsecond
`default_nettype none
module qps_meter (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// meter bundle
	qps_meter_if.meter m
);
	import qps_pkg::*;

	typedef struct packed {
		logic signed [LVL_W-1:0] level;
	} qps_meter_st_t;

	qps_meter_st_t st_reg;
	qps_meter_st_t st_next;
	logic [LVL_W-1:0] add;
	logic [LVL_W-1:0] cost;
	logic signed [LVL_W-1:0] sum;

	always_comb begin
		st_next = st_reg;
		add = LVL_W'(m.rate) * (m.unit[0] ? SCALE_COARSE : 40'h0000000001);
		cost = m.unit[1] ? COST_FRAME : LVL_W'(m.len) * COST_BYTE;
		sum = st_reg.level + $signed(add);
		if (!m.en) begin
			st_next.level = '0;
		end else begin
			if (m.tick) begin
				st_next.level = (sum > $signed(BUCKET_CAP)) ?
					$signed(BUCKET_CAP) : sum;
			end
			if (m.debit) begin
				st_next.level = st_next.level - $signed(cost);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign m.conform = !m.en || !st_reg.level[LVL_W-1];
endmodule // qps_meter
`default_nettype wire

// ===== qps_sched.sv
// egress queue picker: highest queue first or weighted rotation
// assumes eligible mask already folds in shapers and line readiness
`default_nettype none
module qps_sched #(
	parameter int unsigned NUM_Q = qps_pkg::NQ
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// configuration
	input wire logic weighted,
	input wire logic [NUM_Q*qps_pkg::WGT_W-1:0] weights,
	// arbitration
	input wire logic [NUM_Q-1:0] elig,
	input wire logic advance,
	output logic gnt_valid,
	output logic [qps_pkg::QW-1:0] gnt_q
);
	import qps_pkg::*;

	if (NUM_Q != NQ) begin : g_chk
		$error("qps_sched supports exactly eight queues");
	end

	typedef struct packed {
		logic [QW-1:0] ptr;
		logic [WGT_W-1:0] used;
	} qps_sched_st_t;

	qps_sched_st_t st_reg;
	qps_sched_st_t st_next;
	logic [WGT_W-1:0] w [NUM_Q];
	logic [QW:0] cnt;
	logic found;
	logic [QW-1:0] idx;

	for (genvar g = 0; g < NUM_Q; g++) begin : g_w
		assign w[g] = weights[g*WGT_W +: WGT_W];
	end

	always_comb begin
		st_next = st_reg;
		gnt_valid = |elig;
		gnt_q = '0;
		cnt = '0;
		found = 1'b0;
		idx = '0;
		for (int i = 0; i < NUM_Q; i++) begin
			cnt = cnt + (QW+1)'(elig[i]);
		end
		if (!weighted) begin
			for (int i = 0; i < NUM_Q; i++) begin
				if (elig[i]) begin
					gnt_q = QW'(i);
				end
			end
		end else if (cnt == (QW+1)'(1)) begin
			// uncongested: lone queue goes through without weighting
			for (int i = 0; i < NUM_Q; i++) begin
				if (elig[i]) begin
					gnt_q = QW'(i);
				end
			end
		end else if (elig[st_reg.ptr] && st_reg.used < w[st_reg.ptr]) begin
			gnt_q = st_reg.ptr;
		end else begin
			for (int i = 1; i <= NUM_Q; i++) begin
				idx = st_reg.ptr + QW'(i);
				if (!found && elig[idx]) begin
					found = 1'b1;
					gnt_q = idx;
				end
			end
		end
		if (advance && gnt_valid && weighted) begin
			if (gnt_q == st_reg.ptr) begin
				st_next.used = st_reg.used + WGT_W'(1);
			end else begin
				st_next.ptr = gnt_q;
				st_next.used = WGT_W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // qps_sched
`default_nettype wire

// ===== qps_top.sv
// one switch port: ingress policers, egress shapers and scheduler
// assumes frame events and queue status arrive on pclk; apb slave
//
// Our own choices: the register offsets and the APB register port.
`default_nettype none
// How it works
// - port policer has its own enable; disabled means no limiting
// - port policer rate resets to 500, fine units take 100..1000000
// - coarse units limit the port policer rate to 1..3300
// - port policer unit is kbps, Mbps, fps or kfps; kbps after reset
// - flow control set and port in pause mode: pause instead of drop
// - traffic above the policer rate is dropped
// - eight queue policers per port, each with own enable
// - queue policer rate resets to 500 kbps; 100..1000000 or 1..3300
// - egress picks strict priority or weighted mode
// - strict mode serves the highest non-empty queue within its shaper rate, else the highest one with excess set
// - weighted mode rotates queues, weighting only when congested
// - larger weight earns proportionally more service
// - weights reset to 17, accept 1..100, used in weighted mode
// - each weight reads back as percent of total in weighted mode
// - per-queue shapers with enable, rate 500 default, range checked
// - excess option lets a shaped queue use leftover bandwidth
// - port shaper with enable, rate 500 default, range checked
// - port shaper unit kbps or Mbps, kbps after reset
module qps_top #(
	parameter int unsigned TICK_CYCLES = qps_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [qps_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// ingress frame decisions
	input wire logic ing_valid,
	input wire logic [qps_pkg::LEN_W-1:0] ing_len,
	input wire logic [qps_pkg::QW-1:0] ing_queue,
	input wire logic port_fc_mode,
	output logic ing_pass,
	output logic ing_drop,
	output logic pause_tx,
	// egress queue grants
	input wire logic [qps_pkg::NQ-1:0] eg_pending,
	input wire logic [qps_pkg::NQ*qps_pkg::LEN_W-1:0] eg_head_len,
	input wire logic eg_ready,
	output logic eg_grant,
	output logic [qps_pkg::QW-1:0] eg_grant_q
);
	import qps_pkg::*;

	if (TICK_CYCLES < 2 || TICK_CYCLES > 127) begin : g_chk
		$error("qps_top tick divider out of range");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ppol_en;
		qps_unit_t ppol_unit;
		logic ppol_fc;
		logic [RATE_W-1:0] ppol_rate;
		logic [NQ-1:0] qpol_en;
		logic qpol_unit;
		logic [RATE_W-1:0] qpol_rate;
		logic sched_wtd;
		logic [NQ-1:0] qshp_en;
		logic [NQ-1:0] qshp_exc;
		logic qshp_unit;
		logic [NQ-1:0][RATE_W-1:0] qshp_rate;
		logic [NQ-1:0][WGT_W-1:0] wgt;
		logic pshp_en;
		logic pshp_unit;
		logic [RATE_W-1:0] pshp_rate;
		logic [6:0] tick_cnt;
		logic tick;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic ing_pass;
		logic ing_drop;
		logic pause_tx;
		logic [31:0] drop_cnt;
		logic eg_grant;
		logic [QW-1:0] eg_grant_q;
	} qps_top_st_t;

	qps_top_st_t st_reg;
	qps_top_st_t st_next;
	qps_top_st_t st_rst;

	qps_meter_if mif [MET_N] ();

	logic [NQ-1:0] qp_conf;
	logic [NQ-1:0] qs_conf;
	logic [NQ-1:0] elig;
	logic [NQ-1:0] elig_main;
	logic [NQ-1:0] elig_exc;
	logic pp_ok;
	logic ps_ok;
	logic accept;
	logic fc_pass;
	logic go;
	logic gnt_valid;
	logic [QW-1:0] gnt_q;
	logic [LEN_W-1:0] gnt_len;
	logic [9:0] wsum;
	logic [13:0] pct;
	logic [QW-1:0] aq;
	logic [31:0] rd;
	logic err;

	function automatic logic rate_ok(input logic [RATE_W-1:0] r,
		input logic coarse);
		if (coarse) begin
			return r >= RATE_COARSE_MIN && r <= RATE_COARSE_MAX;
		end
		return r >= RATE_FINE_MIN && r <= RATE_FINE_MAX;
	endfunction

	// ----------------------------------------------------------------
	// meters
	// ----------------------------------------------------------------
	for (genvar g = 0; g < MET_N; g++) begin : g_met
		qps_meter u_met (
			.pclk(pclk),
			.presetn(presetn),
			.m(mif[g])
		);
		assign mif[g].tick = st_reg.tick;
	end

	assign mif[MET_PPOL].en = st_reg.ppol_en;
	assign mif[MET_PPOL].unit = st_reg.ppol_unit;
	assign mif[MET_PPOL].rate = st_reg.ppol_rate;
	assign mif[MET_PPOL].debit = accept;
	assign mif[MET_PPOL].len = ing_len;
	assign pp_ok = mif[MET_PPOL].conform;

	for (genvar q = 0; q < NQ; q++) begin : g_q
		assign mif[MET_QPOL+q].en = st_reg.qpol_en[q];
		assign mif[MET_QPOL+q].unit = qps_unit_t'({1'b0, st_reg.qpol_unit});
		assign mif[MET_QPOL+q].rate = st_reg.qpol_rate;
		assign mif[MET_QPOL+q].debit = accept && ing_queue == QW'(q);
		assign mif[MET_QPOL+q].len = ing_len;
		assign qp_conf[q] = mif[MET_QPOL+q].conform;
		assign mif[MET_QSHP+q].en = st_reg.qshp_en[q];
		assign mif[MET_QSHP+q].unit = qps_unit_t'({1'b0, st_reg.qshp_unit});
		assign mif[MET_QSHP+q].rate = st_reg.qshp_rate[q];
		assign mif[MET_QSHP+q].debit = go && gnt_q == QW'(q);
		assign mif[MET_QSHP+q].len = gnt_len;
		assign qs_conf[q] = mif[MET_QSHP+q].conform;
	end

	assign mif[MET_PSHP].en = st_reg.pshp_en;
	assign mif[MET_PSHP].unit = qps_unit_t'({1'b0, st_reg.pshp_unit});
	assign mif[MET_PSHP].rate = st_reg.pshp_rate;
	assign mif[MET_PSHP].debit = go;
	assign mif[MET_PSHP].len = gnt_len;
	assign ps_ok = mif[MET_PSHP].conform;

	// ----------------------------------------------------------------
	// ingress and egress decisions
	// ----------------------------------------------------------------
	assign fc_pass = !pp_ok && qp_conf[ing_queue] && st_reg.ppol_fc &&
		port_fc_mode;
	assign accept = ing_valid &&
		((pp_ok && qp_conf[ing_queue]) || fc_pass);

	assign elig_main = eg_pending & qs_conf;
	assign elig_exc = eg_pending & st_reg.qshp_exc & ~qs_conf;
	assign elig = (!ps_ok || !eg_ready || st_reg.eg_grant) ? '0 :
		(|elig_main ? elig_main : elig_exc);
	assign go = gnt_valid;
	assign gnt_len = eg_head_len[gnt_q*LEN_W +: LEN_W];

	qps_sched #(
		.NUM_Q(NQ)
	) u_sched (
		.pclk(pclk),
		.presetn(presetn),
		.weighted(st_reg.sched_wtd),
		.weights(st_reg.wgt),
		.elig(elig),
		.advance(go),
		.gnt_valid(gnt_valid),
		.gnt_q(gnt_q)
	);

	// ----------------------------------------------------------------
	// register read and write checks
	// ----------------------------------------------------------------
	always_comb begin
		aq = paddr[4:2];
		wsum = '0;
		for (int i = 0; i < NQ; i++) begin
			wsum = wsum + 10'(st_reg.wgt[i]);
		end
		pct = (14'(st_reg.wgt[aq]) * PCT_FULL) / 14'(wsum);
		rd = '0;
		err = 1'b0;
		if (paddr[11:5] == OFS_QSHP_RATE[11:5]) begin
			rd = 32'(st_reg.qshp_rate[aq]);
			err = pwrite && !rate_ok(pwdata[RATE_W-1:0],
				st_reg.qshp_unit);
		end else if (paddr[11:5] == OFS_WGT[11:5]) begin
			rd = 32'(st_reg.wgt[aq]);
			err = pwrite && (pwdata[31:0] < 32'(WGT_MIN) ||
				pwdata[31:0] > 32'(WGT_MAX));
		end else if (paddr[11:5] == OFS_PCT[11:5]) begin
			rd = st_reg.sched_wtd ? 32'(pct) : 32'h00000000;
			err = pwrite;
		end else begin
			unique case (paddr)
				OFS_PPOL_CFG: begin
					rd = 32'({st_reg.ppol_fc, st_reg.ppol_unit, st_reg.ppol_en});
					err = pwrite && !rate_ok(st_reg.ppol_rate,
						pwdata[PPOL_UNIT_LSB]);
				end
				OFS_PPOL_RATE: begin
					rd = 32'(st_reg.ppol_rate);
					err = pwrite && !rate_ok(pwdata[RATE_W-1:0],
						st_reg.ppol_unit[0]);
				end
				OFS_QPOL_CFG: begin
					rd = 32'({st_reg.qpol_unit, st_reg.qpol_en});
					err = pwrite && !rate_ok(st_reg.qpol_rate,
						pwdata[QPOL_UNIT_BIT]);
				end
				OFS_QPOL_RATE: begin
					rd = 32'(st_reg.qpol_rate);
					err = pwrite && !rate_ok(pwdata[RATE_W-1:0],
						st_reg.qpol_unit);
				end
				OFS_SCHED_CFG: begin
					rd = 32'(st_reg.sched_wtd);
				end
				OFS_QSHP_CFG: begin
					rd = 32'({st_reg.qshp_unit, st_reg.qshp_exc, st_reg.qshp_en});
					for (int i = 0; i < NQ; i++) begin
						if (pwrite && !rate_ok(st_reg.qshp_rate[i],
							pwdata[QSHP_UNIT_BIT])) begin
							err = 1'b1;
						end
					end
				end
				OFS_PSHP_CFG: begin
					rd = 32'({st_reg.pshp_unit, st_reg.pshp_en});
					err = pwrite && !rate_ok(st_reg.pshp_rate,
						pwdata[PSHP_UNIT_BIT]);
				end
				OFS_PSHP_RATE: begin
					rd = 32'(st_reg.pshp_rate);
					err = pwrite && !rate_ok(pwdata[RATE_W-1:0],
						st_reg.pshp_unit);
				end
				OFS_STATUS: begin
					rd = 32'({pp_ok, ps_ok, 5'h00, st_reg.eg_grant_q, eg_pending});
					err = pwrite;
				end
				OFS_DROP_CNT: begin
					rd = st_reg.drop_cnt;
					err = pwrite;
				end
				default: begin
					err = 1'b1;
				end
			endcase
		end
		if (pwrite && pstrb != 4'hf) begin
			err = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		// apb: setup latches the answer, one access cycle completes it
		st_next.pready = psel && !penable && !st_reg.pready;
		if (psel && !penable) begin
			st_next.prdata = pwrite ? 32'h00000000 : rd;
			st_next.pslverr = err;
		end
		if (psel && penable && st_reg.pready && pwrite && !st_reg.pslverr) begin
			if (paddr[11:5] == OFS_QSHP_RATE[11:5]) begin
				st_next.qshp_rate[aq] = pwdata[RATE_W-1:0];
			end else if (paddr[11:5] == OFS_WGT[11:5]) begin
				st_next.wgt[aq] = pwdata[WGT_W-1:0];
			end else if (paddr == OFS_PPOL_CFG) begin
				st_next.ppol_en = pwdata[PPOL_EN_BIT];
				st_next.ppol_unit = qps_unit_t'(pwdata[PPOL_UNIT_LSB +: 2]);
				st_next.ppol_fc = pwdata[PPOL_FC_BIT];
			end else if (paddr == OFS_PPOL_RATE) begin
				st_next.ppol_rate = pwdata[RATE_W-1:0];
			end else if (paddr == OFS_QPOL_CFG) begin
				st_next.qpol_en = pwdata[NQ-1:0];
				st_next.qpol_unit = pwdata[QPOL_UNIT_BIT];
			end else if (paddr == OFS_QPOL_RATE) begin
				st_next.qpol_rate = pwdata[RATE_W-1:0];
			end else if (paddr == OFS_SCHED_CFG) begin
				st_next.sched_wtd = pwdata[SCHED_WTD_BIT];
			end else if (paddr == OFS_QSHP_CFG) begin
				st_next.qshp_en = pwdata[NQ-1:0];
				st_next.qshp_exc = pwdata[QSHP_EXC_LSB +: NQ];
				st_next.qshp_unit = pwdata[QSHP_UNIT_BIT];
			end else if (paddr == OFS_PSHP_CFG) begin
				st_next.pshp_en = pwdata[PSHP_EN_BIT];
				st_next.pshp_unit = pwdata[PSHP_UNIT_BIT];
			end else if (paddr == OFS_PSHP_RATE) begin
				st_next.pshp_rate = pwdata[RATE_W-1:0];
			end
		end
		// microsecond refill tick
		st_next.tick = 1'b0;
		if (st_reg.tick_cnt == 7'(TICK_CYCLES - 1)) begin
			st_next.tick_cnt = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.tick_cnt = st_reg.tick_cnt + 7'h01;
		end
		// ingress outcome
		st_next.ing_pass = accept;
		st_next.ing_drop = ing_valid && !accept;
		st_next.pause_tx = ing_valid && fc_pass;
		if (ing_valid && !accept) begin
			st_next.drop_cnt = st_reg.drop_cnt + 32'h00000001;
		end
		// egress grant
		st_next.eg_grant = go;
		if (go) begin
			st_next.eg_grant_q = gnt_q;
		end
	end

	always_comb begin
		st_rst = '0;
		st_rst.ppol_unit = QPS_KBPS;
		st_rst.ppol_rate = RATE_DEF;
		st_rst.qpol_rate = RATE_DEF;
		st_rst.pshp_rate = RATE_DEF;
		for (int i = 0; i < NQ; i++) begin
			st_rst.qshp_rate[i] = RATE_DEF;
			st_rst.wgt[i] = WGT_DEF;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= st_rst;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign ing_pass = st_reg.ing_pass;
	assign ing_drop = st_reg.ing_drop;
	assign pause_tx = st_reg.pause_tx;
	assign eg_grant = st_reg.eg_grant;
	assign eg_grant_q = st_reg.eg_grant_q;
endmodule // qps_top
`default_nettype wire

// ===== qps_link_partner.sv
// far side of the egress queues: frame stock per queue
// assumes the bench pulses add bits; one frame leaves per grant
`default_nettype none
module qps_link_partner (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench control
	input wire logic [7:0] add,
	input wire logic stall,
	// egress side
	input wire logic eg_grant,
	input wire logic [2:0] eg_grant_q,
	output logic [7:0] eg_pending,
	output logic [127:0] eg_head_len,
	output logic eg_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	import qps_pkg::*;
	logic [3:0] cnt [8];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) cnt[i] <= 4'h0;
		end else begin
			for (int i = 0; i < 8; i++) cnt[i] <= cnt[i] + {3'h0, add[i]}
				- {3'h0, eg_grant && eg_grant_q == 3'(i)};
		end
	end
	always_comb begin
		for (int i = 0; i < 8; i++) eg_pending[i] = cnt[i] != 4'h0;
	end
	assign eg_head_len = {8{16'h0040}};
	assign eg_ready = !stall;
endmodule // qps_link_partner
`default_nettype wire

// ===== qps_checker.sv
// port assertions of qps_top
// assumes bind into qps_top, one clock domain
`default_nettype none
module qps_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// ingress
	input wire logic ing_valid,
	input wire logic ing_pass,
	input wire logic ing_drop,
	input wire logic pause_tx,
	// egress
	input wire logic [qps_pkg::NQ-1:0] eg_pending,
	input wire logic eg_ready,
	input wire logic eg_grant,
	input wire logic [qps_pkg::QW-1:0] eg_grant_q
);
	timeunit 1ns;
	timeprecision 100ps;
	import qps_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	one_answer_a: assert property (ing_valid |=> ing_pass ^ ing_drop)
		else $error("frame without single verdict");
	no_answer_a: assert property (!ing_valid |=> !ing_pass && !ing_drop)
		else $error("verdict without frame");
	pause_pass_a: assert property (pause_tx |-> ing_pass)
		else $error("pause without pass");
	grant_gap_a: assert property (eg_grant |=> !eg_grant)
		else $error("grants too close");
	grant_ready_a: assert property (eg_grant |-> $past(eg_ready))
		else $error("grant while line busy");
	grant_pend_a: assert property (eg_grant |->
		(($past(eg_pending) >> eg_grant_q) & 8'h01) != 8'h00)
		else $error("grant to empty queue");
	grant_hold_a: assert property (!eg_grant |-> $stable(eg_grant_q))
		else $error("grant queue moved");
endmodule // qps_checker
bind qps_top qps_checker chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready),
	.ing_valid(ing_valid), .ing_pass(ing_pass), .ing_drop(ing_drop),
	.pause_tx(pause_tx), .eg_pending(eg_pending), .eg_ready(eg_ready),
	.eg_grant(eg_grant), .eg_grant_q(eg_grant_q));
`default_nettype wire

// ===== qps_top_tb.sv
// bench of qps_top: register table, policing, egress order, shaping
// assumes qps_link_partner on the egress side, fast refill tick
`default_nettype none
module qps_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import qps_pkg::*;
	// ----------------------------------------------------------------
	// signals and tasks
	// ----------------------------------------------------------------
	typedef struct packed {
		logic w;
		logic [11:0] a;
		logic [31:0] d;
		logic e;
	} qps_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, ing_pass, ing_drop, pause_tx, eg_grant, eg_ready;
	logic ing_valid = 1'b0, port_fc_mode = 1'b0, stall = 1'b1;
	logic [7:0] add = 8'h00, eg_pending;
	logic [127:0] eg_head_len;
	logic [2:0] eg_grant_q;
	logic [2:0] gq [8];
	int failures = 0, check_count = 0, cyc = 0;
	qps_row_t rows [22] = '{
		'{1'b0, 12'h000, 32'h0, 1'b0}, '{1'b0, 12'h004, 32'h1f4, 1'b0},
		'{1'b0, 12'h00c, 32'h1f4, 1'b0}, '{1'b0, 12'h040, 32'h1f4, 1'b0},
		'{1'b0, 12'h01c, 32'h1f4, 1'b0}, '{1'b0, 12'h018, 32'h0, 1'b0},
		'{1'b0, 12'h060, 32'h11, 1'b0}, '{1'b0, 12'h080, 32'h0, 1'b0},
		'{1'b1, 12'h004, 32'h63, 1'b1}, '{1'b1, 12'h004, 32'hf4241, 1'b1},
		'{1'b1, 12'h004, 32'h64, 1'b0}, '{1'b1, 12'h000, 32'h2, 1'b0},
		'{1'b1, 12'h004, 32'hce5, 1'b1}, '{1'b1, 12'h004, 32'hce4, 1'b0},
		'{1'b1, 12'h060, 32'h0, 1'b1}, '{1'b1, 12'h060, 32'h65, 1'b1},
		'{1'b1, 12'h060, 32'h64, 1'b0}, '{1'b1, 12'h00c, 32'h63, 1'b1},
		'{1'b1, 12'h018, 32'h2, 1'b0}, '{1'b1, 12'h01c, 32'hce5, 1'b1},
		'{1'b1, 12'h020, 32'h0, 1'b1}, '{1'b1, 12'h100, 32'h0, 1'b1}};
	qps_top #(.TICK_CYCLES(2)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ing_valid(ing_valid), .ing_len(16'h0040),
		.ing_queue(3'h0), .port_fc_mode(port_fc_mode), .ing_pass(ing_pass),
		.ing_drop(ing_drop), .pause_tx(pause_tx), .eg_pending(eg_pending),
		.eg_head_len(eg_head_len), .eg_ready(eg_ready), .eg_grant(eg_grant),
		.eg_grant_q(eg_grant_q));
	qps_link_partner link_u (.pclk(pclk), .presetn(presetn), .add(add),
		.stall(stall), .eg_grant(eg_grant), .eg_grant_q(eg_grant_q),
		.eg_pending(eg_pending), .eg_head_len(eg_head_len),
		.eg_ready(eg_ready));
	always #4 pclk = ~pclk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [11:0] a,
			input logic [31:0] d, input logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk({31'h0, pready}, 32'h1);
		if (!w) chk(prdata, d);
		chk({31'h0, pslverr}, {31'h0, e});
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic frame(input logic p, input logic dr, input logic ps);
		@(posedge pclk);
		ing_valid <= 1'b1;
		@(posedge pclk);
		ing_valid <= 1'b0;
		@(negedge pclk);
		chk({29'h0, ing_pass, ing_drop, pause_tx}, {29'h0, p, dr, ps});
		@(posedge pclk);
	endtask
	task automatic grants(input int n);
		int k;
		k = 0;
		while (k < n) begin
			@(negedge pclk);
			if (eg_grant === 1'b1) gq[k++] = eg_grant_q;
		end
		@(posedge pclk);
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		int n0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) acc(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
		$display("test register table done");
		acc(1'b1, OFS_PPOL_CFG, 32'h5, 1'b0);
		frame(1'b1, 1'b0, 1'b0);
		frame(1'b0, 1'b1, 1'b0);
		acc(1'b0, OFS_DROP_CNT, 32'h1, 1'b0);
		port_fc_mode <= 1'b1;
		acc(1'b1, OFS_PPOL_CFG, 32'hd, 1'b0);
		frame(1'b1, 1'b0, 1'b1);
		acc(1'b1, OFS_PPOL_CFG, 32'h4, 1'b0);
		frame(1'b1, 1'b0, 1'b0);
		$display("test policing done");
		add <= 8'h24;
		@(posedge pclk);
		add <= 8'h00;
		stall <= 1'b0;
		grants(2);
		chk({29'h0, gq[0]}, 32'h5);
		chk({29'h0, gq[1]}, 32'h2);
		$display("test strict order done");
		stall <= 1'b1;
		acc(1'b1, OFS_WGT + 12'h004, 32'h1, 1'b0);
		acc(1'b1, OFS_SCHED_CFG, 32'h1, 1'b0);
		acc(1'b0, OFS_PCT, 32'h31, 1'b0);
		acc(1'b0, OFS_PCT + 12'h008, 32'h8, 1'b0);
		add <= 8'h03;
		repeat (3) @(posedge pclk);
		add <= 8'h00;
		stall <= 1'b0;
		grants(3);
		n0 = 0;
		for (int i = 0; i < 3; i++) n0 += (gq[i] === 3'h0);
		chk({31'h0, n0 >= 2}, 32'h1);
		grants(3);
		$display("test weighted done");
		acc(1'b1, OFS_PSHP_RATE, 32'h64, 1'b0);
		acc(1'b1, OFS_PSHP_CFG, 32'h1, 1'b0);
		add <= 8'h08;
		repeat (2) @(posedge pclk);
		add <= 8'h00;
		n0 = 0;
		repeat (60) begin
			@(negedge pclk);
			n0 += (eg_grant === 1'b1);
		end
		@(posedge pclk);
		chk(n0, 32'h1);
		$display("test port shaper done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		acc(1'b0, OFS_PSHP_RATE, 32'h1f4, 1'b0);
		acc(1'b0, OFS_SCHED_CFG, 32'h0, 1'b0);
		$display("test second reset done");
		results();
	end
endmodule // qps_top_tb
`default_nettype wire
